// >>> design/serial_rx_end.sv
// receive path: shifter, two-entry fifo, status and control registers
`default_nettype none
module serial_rx_end
  import serial_rx_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  // software register port
  input  wire logic [1:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // interrupt request and global enable
  input  wire logic       i_global_irq_en,
  output logic            o_rx_irq,
  // pin ownership: high while the receiver overrides the port
  output logic            o_pin_override,
  // line
  serial_line_if.receiver line
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned EW = MAX_DATA_BITS + 3;

  typedef enum logic [2:0] {IDLE, DATA, PARITY, STOP, HOLD} rx_state_t;

  rx_state_t        state_r;
  logic [7:0]       ctrl_b_r, ctrl_c_r;
  logic [8:0]       shift_r;
  logic [3:0]       cnt_r;
  logic             par_r, fe_r, pe_r, dor_r;
  logic [EW-1:0]    mem_r [DEPTH];
  logic [PW-1:0]    wp_r, rp_r;
  logic [PW:0]      fill_r;
  logic [7:0]       rdata_r;

  logic       rx_en, par_en, par_odd, full, empty, rxc;
  logic       pop, push, start_seen, line_in;
  logic [2:0] size_code;
  logic [3:0] nbits;
  logic [8:0] data_mask;
  logic       par_calc;
  logic [EW-1:0] head;

  // decode of control fields
  assign rx_en      = ctrl_b_r[CB_RXEN];
  assign par_en     = ctrl_c_r[CC_UPM1];
  assign par_odd    = ctrl_c_r[CC_UPM0];
  assign size_code  = {ctrl_b_r[CB_SZ2], ctrl_c_r[CC_SZ1], ctrl_c_r[CC_SZ0]};
  assign nbits      = (size_code == CHAR_SIZE_9) ? CHAR_NINE
                    : (size_code[2] ? 4'h8 : CHAR_BASE + {2'h0, size_code[1:0]});
  assign data_mask  = (9'h001 << nbits) - 9'h001;
  assign o_pin_override = rx_en;
  assign line_in    = rx_en ? line.line : 1'b1;

  // fifo status; rxc is "unread data present" while the receiver is enabled
  assign empty = (fill_r == '0);
  assign full  = (fill_r == (PW+1)'(DEPTH));
  // gated by the enable so the flag drops in the cycle of a disable
  assign rxc   = ~empty && rx_en;
  assign head  = mem_r[rp_r];
  assign pop   = i_rd && (i_addr == ADDR_DATA) && !empty;
  assign push  = rx_en && (state_r == HOLD) && (!full || pop);
  assign start_seen = line.bit_tick && !line_in && (state_r == IDLE || state_r == HOLD);
  // even parity with low select zero, odd with one
  assign par_calc = (^(shift_r & data_mask)) ^ par_odd ^ par_r;

  // interrupt only from the complete flag, never the error flags
  assign o_rx_irq = ctrl_b_r[CB_RXCIE] && rxc && i_global_irq_en;

  // control registers; status writes leave the error flags alone
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ctrl_b_r <= CTRL_B_RESET;
      ctrl_c_r <= CTRL_C_RESET;
    end else if (i_wr) begin
      if (i_addr == ADDR_CTRL_B) ctrl_b_r <= i_wdata & ~(8'h01 << CB_RXB8);
      if (i_addr == ADDR_CTRL_C) ctrl_c_r <= i_wdata;
    end
  end

  // frame shifter; a held frame waits in HOLD while the fifo is full
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !rx_en) begin
      state_r   <= IDLE;
      shift_r   <= '0;
      cnt_r     <= 4'h0;
      par_r     <= 1'b0;
      fe_r      <= 1'b0;
      pe_r      <= 1'b0;
    end else begin
      unique case (state_r)
        IDLE: if (start_seen) begin
          state_r <= DATA;
          cnt_r   <= 4'h0;
          shift_r <= '0;
        end
        DATA: if (line.bit_tick) begin
          shift_r[cnt_r] <= line_in;
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == nbits - 4'h1) state_r <= par_en ? PARITY : STOP;
        end
        PARITY: if (line.bit_tick) begin
          par_r   <= line_in;
          state_r <= STOP;
        end
        STOP: if (line.bit_tick) begin
          fe_r    <= ~line_in;
          pe_r    <= par_en && par_calc;
          state_r <= HOLD;
        end
        HOLD: begin
          // second stop bits pass here unseen
          // a new start always begins the next frame; held frame lost if not pushed
          if (start_seen) begin
            state_r <= DATA;
            cnt_r   <= 4'h0;
            shift_r <= '0;
          end else if (push) begin
            state_r <= IDLE;
          end
        end
        default: state_r <= IDLE;
      endcase
      if (state_r != PARITY && state_r != STOP && state_r != HOLD && state_r != DATA) par_r <= 1'b0;
    end
  end

  // overrun latch: set wins over clear on a lost frame
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !rx_en) dor_r <= 1'b0;
    else if (state_r == HOLD && !push && start_seen) dor_r <= 1'b1;
    else if (push) dor_r <= 1'b0;
  end

  // fifo storage: data, ninth bit and three error flags per entry
  always_ff @(posedge i_sys_clk) begin
    if (push) mem_r[wp_r] <= {fe_r, dor_r, pe_r, shift_r & data_mask};
  end

  // fifo pointers; disable flushes at once
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !rx_en) begin
      wp_r   <= '0;
      rp_r   <= '0;
      fill_r <= '0;
    end else begin
      if (push) wp_r <= (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + PW'(1);
      if (pop)  rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + PW'(1);
      fill_r <= fill_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // read data one cycle after the strobe; fields of the entry at the head
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) rdata_r <= 8'h00;
    else if (i_rd) begin
      unique case (i_addr)
        ADDR_DATA:   rdata_r <= empty ? 8'h00 : head[7:0];
        ADDR_STATUS: rdata_r <= {rxc, 2'h0, head[EW-1] & rxc, head[EW-2] & rxc,
                                 head[EW-3] & rxc, 2'h0};
        ADDR_CTRL_B: rdata_r <= (ctrl_b_r & ~(8'h01 << CB_RXB8))
                              | ({7'h00, head[8] & rxc & (size_code == CHAR_SIZE_9)} << CB_RXB8);
        ADDR_CTRL_C: rdata_r <= ctrl_c_r;
        default:     rdata_r <= 8'h00;
      endcase
    end
  end
  assign o_rdata = rdata_r;
endmodule
`default_nettype wire

// >>> design/serial_tx_end.sv
// remote serial transmitter driving the receive line
`default_nettype none
module serial_tx_end
  import serial_rx_pkg::*;
#(
  parameter int unsigned BIT_DIV = BIT_DIV_DEFAULT
) (
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  // frame request
  input  wire logic       i_send,
  input  wire logic [8:0] i_data,
  input  wire logic [3:0] i_nbits,
  input  wire logic       i_par_en,
  input  wire logic       i_par_odd,
  input  wire logic       i_stop_bad,
  input  wire logic       i_two_stop,
  output logic            o_busy,
  // line
  serial_line_if.transmitter line
);
  localparam int unsigned DW = $clog2(BIT_DIV);
  localparam int unsigned FW = 13;

  logic [DW-1:0] div_r;
  logic          tick;
  logic [FW-1:0] sh_r;
  logic [3:0]    left_r;
  logic          drive_r;
  logic          par;

  // bit-rate enable from the system clock
  assign tick = (div_r == DW'(BIT_DIV - 1));
  assign par  = (^(i_data & ((9'h001 << i_nbits) - 9'h001))) ^ i_par_odd;
  assign o_busy = (left_r != 4'h0);
  assign line.bit_tick  = tick;
  assign line.line_o    = sh_r[0];
  assign line.line_oe_n = ~drive_r;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) div_r <= '0;
    else div_r <= tick ? '0 : div_r + DW'(1);
  end

  // frame assembled lsb first; bits beyond the frame stay idle high
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sh_r    <= '1;
      left_r  <= 4'h0;
      drive_r <= 1'b0;
    end else if (!o_busy && i_send) begin
      sh_r    <= {1'b1, (FW-1)'({i_data, 1'b0}) | ~(FW-1)'((13'h1 << (i_nbits + 4'h1)) - 13'h1)};
      sh_r[i_nbits+4'h1] <= i_par_en ? par : ~i_stop_bad;
      if (i_par_en) sh_r[i_nbits+4'h2] <= ~i_stop_bad;
      left_r  <= i_nbits + 4'h2 + (i_par_en ? 4'h1 : 4'h0) + (i_two_stop ? 4'h1 : 4'h0);
      drive_r <= 1'b1;
    end else if (tick && o_busy) begin
      sh_r   <= {1'b1, sh_r[FW-1:1]};
      left_r <= left_r - 4'h1;
      if (left_r == 4'h1) drive_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> inc/serial_line_if.sv
// serial receive line between a remote transmitter and the receiver
`default_nettype none
interface serial_line_if;
  logic line_o;     // transmitter drive level
  logic line_oe_n;  // low while transmitter drives
  logic bit_tick;   // shared bit-rate enable pulse
  logic line;       // resolved line level, idle high
  assign line = line_oe_n ? 1'b1 : line_o;
  modport transmitter (output line_o, output line_oe_n, output bit_tick);
  modport receiver    (input line, input bit_tick);
endinterface
`default_nettype wire

// >>> inc/serial_rx_pkg.sv
// shared constants for the serial receive path and its line driver
`default_nettype none
package serial_rx_pkg;
  // data bits carried per frame at most, and fifo depth
  localparam int unsigned MAX_DATA_BITS = 9;
  localparam int unsigned FIFO_DEPTH    = 2;
  // character size codes
  localparam logic [2:0] CHAR_SIZE_5 = 3'h0;
  localparam logic [2:0] CHAR_SIZE_9 = 3'h7;
  localparam logic [3:0] CHAR_BASE   = 4'h5;
  localparam logic [3:0] CHAR_NINE   = 4'h9;
  // serial bit clock divider: 20 MHz / 16 = 1.25 Mbit/s default
  localparam int unsigned BIT_DIV_DEFAULT = 16;
  // software register addresses (device end)
  localparam logic [1:0] ADDR_DATA   = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [1:0] ADDR_CTRL_B = 2'h2;
  localparam logic [1:0] ADDR_CTRL_C = 2'h3;
  // status register fields
  localparam int unsigned ST_RXC = 7;
  localparam int unsigned ST_FE  = 4;
  localparam int unsigned ST_DOR = 3;
  localparam int unsigned ST_UPE = 2;
  // control register b fields
  localparam int unsigned CB_RXCIE = 7;
  localparam int unsigned CB_RXEN  = 4;
  localparam int unsigned CB_SZ2   = 2;
  localparam int unsigned CB_RXB8  = 1;
  // control register c fields
  localparam int unsigned CC_UPM1 = 5;
  localparam int unsigned CC_UPM0 = 4;
  localparam int unsigned CC_USBS = 3;
  localparam int unsigned CC_SZ1  = 2;
  localparam int unsigned CC_SZ0  = 1;
  // reset values
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  localparam logic [7:0] CTRL_C_RESET = 8'h06;
endpackage
`default_nettype wire

// >>> test/serial_rx_sva.sv
// assertions on the shared bit tick and the receiver's software side
`default_nettype none
module serial_rx_sva
  import serial_rx_pkg::*;
(
  // clock, reset and link
  input wire logic       i_sys_clk,
  input wire logic       i_rst_n,
  input wire logic       bit_tick,
  // software port and receiver outputs
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_global_irq_en,
  input wire logic       o_rx_irq,
  input wire logic       o_pin_override
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // decodes of the control writes that move the enable, and of a data read
  wire logic off_wr = i_wr && i_addr == ADDR_CTRL_B && !i_wdata[CB_RXEN];
  wire logic on_wr  = i_wr && i_addr == ADDR_CTRL_B && i_wdata[CB_RXEN];
  wire logic dat_rd = i_rd && i_addr == ADDR_DATA;
  // bench runs the divider at 4, so three quiet cycles follow a tick
  tick_space_a: assert property (bit_tick |=> !bit_tick [*3])
    else $error("bit tick spacing too short");
  irq_global_a: assert property (o_rx_irq |-> i_global_irq_en)
    else $error("interrupt without global enable");
  irq_enable_a: assert property (o_rx_irq |-> o_pin_override)
    else $error("interrupt while receiver disabled");
  irq_flush_a: assert property (off_wr |=> !o_rx_irq)
    else $error("interrupt survives receiver disable");
  irq_drop_a: assert property ($fell(o_rx_irq) |-> $past(dat_rd) || $past(i_wr) || !i_global_irq_en)
    else $error("interrupt dropped without cause");
  rdata_hold_a: assert property (!$past(i_rd) |-> $stable(o_rdata))
    else $error("read data moved without a read");
  pin_take_a: assert property ($rose(o_pin_override) |-> $past(on_wr))
    else $error("pin taken without enable write");
  pin_free_a: assert property ($fell(o_pin_override) |-> $past(off_wr))
    else $error("pin released without disable write");
  // main scenarios reached
  cover property ($rose(o_rx_irq));
  cover property ($fell(o_pin_override));
  cover property ($past(dat_rd) && o_rdata != 8'h00);
endmodule
`default_nettype wire

// >>> test/tb_serial_receiver_buffer_flags.sv
// self-checking bench: transmitter end drives the receiver end
`default_nettype none
module tb_serial_receiver_buffer_flags
  import serial_rx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       i_sys_clk = 1'b0;
  logic       i_rst_n = 1'b0;
  logic [1:0] i_addr = 2'h0;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic       i_global_irq_en = 1'b1;
  logic       i_send = 1'b0;
  logic [8:0] i_data = 9'h000;
  logic [3:0] i_nbits = 4'h8;
  logic [3:0] fl = 4'h0;
  logic [7:0] o_rdata;
  logic       o_rx_irq;
  logic       o_pin_override;
  logic       o_busy;
  int         n_fail = 0;
  int         n_compared = 0;
  serial_line_if line_if ();
  always #25 i_sys_clk = ~i_sys_clk;
  // short divider keeps frames near forty cycles
  serial_tx_end #(.BIT_DIV(4)) u_serial_tx_end (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_send(i_send),
    .i_data(i_data), .i_nbits(i_nbits), .i_par_en(fl[0]), .i_par_odd(fl[1]), .i_stop_bad(fl[2]),
    .i_two_stop(fl[3]), .o_busy(o_busy), .line(line_if.transmitter));
  serial_rx_end u_serial_rx_end (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_global_irq_en(i_global_irq_en), .o_rx_irq(o_rx_irq),
    .o_pin_override(o_pin_override), .line(line_if.receiver));
  serial_rx_sva chk_sva (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .bit_tick(line_if.bit_tick), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_global_irq_en(i_global_irq_en),
    .o_rx_irq(o_rx_irq), .o_pin_override(o_pin_override));
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] s);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  // read data is only looked at in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [7:0] e, input string nm);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 chk(nm, {1'b0, e}, {1'b0, o_rdata});
  endtask
  // f is two stop, bad stop, odd parity, parity on
  task automatic send(input logic [8:0] d, input logic [3:0] n, input logic [3:0] f);
    @(posedge i_sys_clk);
    i_data <= d;
    i_nbits <= n;
    fl <= f;
    i_send <= 1'b1;
    @(posedge i_sys_clk);
    i_send <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    for (int k = 0; k < 400 && o_busy; k++) @(posedge i_sys_clk);
    repeat (4) @(posedge i_sys_clk);
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    n_fail++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    rd(ADDR_CTRL_B, CTRL_B_RESET, "ctrl_b");
    rd(ADDR_CTRL_C, CTRL_C_RESET, "ctrl_c");
    // enabled with interrupt; two stop bits must not upset the frame flag
    wr(ADDR_CTRL_B, 8'h90);
    send(9'h0a5, 4'h8, 4'h8);
    rd(ADDR_STATUS, 8'h80, "status");
    chk("irq", 9'h001, {8'h00, o_rx_irq});
    @(posedge i_sys_clk);
    i_global_irq_en <= 1'b0;
    @(posedge i_sys_clk);
    chk("irq", 9'h000, {8'h00, o_rx_irq});
    i_global_irq_en <= 1'b1;
    rd(ADDR_DATA, 8'ha5, "data");
    rd(ADDR_STATUS, 8'h00, "status");
    chk("irq", 9'h000, {8'h00, o_rx_irq});
    // bad stop on the older frame only; status writes must not touch flags
    send(9'h03c, 4'h8, 4'h4);
    send(9'h0c3, 4'h8, 4'h0);
    wr(ADDR_STATUS, 8'h00);
    rd(ADDR_STATUS, 8'h90, "status");
    rd(ADDR_DATA, 8'h3c, "data");
    rd(ADDR_STATUS, 8'h80, "status");
    rd(ADDR_DATA, 8'hc3, "data");
    rd(ADDR_STATUS, 8'h00, "status");
    // every short size code: upper bits read zero
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CTRL_C, 8'(c * 2));
      send(9'h1ff, 4'(c + 5), 4'h0);
      rd(ADDR_DATA, 8'((1 << (c + 5)) - 1), "data");
    end
    // nine bits: ninth bit belongs to the head entry
    wr(ADDR_CTRL_B, 8'h94);
    send(9'h155, 4'h9, 4'h0);
    rd(ADDR_CTRL_B, 8'h96, "ctrl_b");
    rd(ADDR_DATA, 8'h55, "data");
    rd(ADDR_CTRL_B, 8'h94, "ctrl_b");
    wr(ADDR_CTRL_B, 8'h90);
    // both parity modes against both sent parities
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CTRL_C, 8'h26 | 8'(m[0] * 16));
      send(9'h0b7, 4'h8, {2'b00, m[1], 1'b1});
      rd(ADDR_STATUS, 8'h80 | 8'((m[0] ^ m[1]) * 4), "status");
      rd(ADDR_DATA, 8'hb7, "data");
    end
    wr(ADDR_CTRL_C, 8'h06);
    // four frames into two entries: the third is lost
    for (int i = 1; i < 5; i++) send(9'(i * 17), 4'h8, 4'h0);
    rd(ADDR_DATA, 8'h11, "data");
    rd(ADDR_STATUS, 8'h80, "status");
    rd(ADDR_DATA, 8'h22, "data");
    rd(ADDR_STATUS, 8'h88, "status");
    rd(ADDR_DATA, 8'h44, "data");
    send(9'h055, 4'h8, 4'h0);
    rd(ADDR_STATUS, 8'h80, "status");
    // disable flushes the stored frame and frees the pin
    wr(ADDR_CTRL_B, 8'h00);
    rd(ADDR_STATUS, 8'h00, "status");
    chk("pin", 9'h000, {8'h00, o_pin_override});
    // disable in mid-frame drops the reception
    wr(ADDR_CTRL_B, 8'h90);
    fork
      send(9'h0f0, 4'h8, 4'h0);
      begin
        repeat (20) @(posedge i_sys_clk);
        wr(ADDR_CTRL_B, 8'h00);
      end
    join
    wr(ADDR_CTRL_B, 8'h90);
    rd(ADDR_STATUS, 8'h00, "status");
    chk("irq", 9'h000, {8'h00, o_rx_irq});
    end_of_test();
  end
endmodule
`default_nettype wire
